// ===== fpi_cfg.svh
// Constants for the flash pin-interface host controller
// Assumes inclusion by the controller module, the memory model and the bench
`ifndef FPI_CFG_SVH
`define FPI_CFG_SVH
// Register word offsets (byte addresses)
`define FPI_OFF_CTRL    12'h000
`define FPI_OFF_ADDR    12'h004
`define FPI_OFF_WDATA   12'h008
`define FPI_OFF_RDATA   12'h00C
`define FPI_OFF_STAT    12'h010
`define FPI_OFF_CS      12'h014
// Control register fields
`define FPI_CTL_GO      0
`define FPI_CTL_WR      1
`define FPI_CTL_RST     2
`define FPI_CTL_WIDE    3
`define FPI_CTL_PEN     4
// Status register fields
`define FPI_ST_BUSY     0
`define FPI_ST_STSLO    1
`define FPI_ST_RSTBSY   2
// Chip-select pattern reset value: third high, others low
`define FPI_CS_RST      3'h4
// Timing in ns and derived cycle counts at 5 ns
`define FPI_CLK_NS      5
`define FPI_T_SETUP_NS  20
`define FPI_T_STROBE_NS 70
`define FPI_T_HOLD_NS   20
`define FPI_T_RSTLO_NS  10000
`define FPI_T_RECOV_NS  30000
`define FPI_CYC(t) (((t) + `FPI_CLK_NS - 1) / `FPI_CLK_NS)
`define FPI_CNT_W       16
`endif

// ===== fpi_pkg.sv
// Types shared by the flash pin-interface host controller
// Assumes fpi_cfg.svh defines the constants
package fpi_pkg;
  // Pins the host drives toward the memory
  typedef struct packed {
    logic [21:0] addr;
    logic [2:0]  cs;
    logic        oe_n;
    logic        we_n;
    logic        reset_powerdown_n;
    logic        wide;
    logic        program_erase_enable;
  } fpi_pins_t;
  // Bus cycle sequencer states
  typedef enum logic [2:0] {
    FPI_RST_LO, FPI_RST_REC, FPI_IDLE, FPI_SETUP, FPI_STROBE, FPI_HOLD
  } fpi_state_t;
endpackage : fpi_pkg

// ===== fpi_host.sv
// Host controller driving a parallel NOR flash through its pins
// Assumes an APB master, one 200 MHz clock, memory pins synchronous
//
// Functional notes
// - Host keeps device enabled while addressing
// - Host holds reset low minimum time
// - Tie memory reset to system reset
// - Host drives program enable from its control register bit, idle included
`timescale 1ns/1ps
`include "fpi_cfg.svh"
module fpi_host
  import fpi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output fpi_pins_t        pins,
  input  wire logic [15:0] data_bus_lines_in,
  output logic      [15:0] data_bus_lines_out,
  output logic      [15:0] data_bus_lines_oe_n,
  input  wire logic        controller_status_pin
);

  localparam logic [`FPI_CNT_W-1:0] SETUP_CYC =
    `FPI_CNT_W'(`FPI_CYC(`FPI_T_SETUP_NS));
  localparam logic [`FPI_CNT_W-1:0] STROBE_CYC =
    `FPI_CNT_W'(`FPI_CYC(`FPI_T_STROBE_NS));
  localparam logic [`FPI_CNT_W-1:0] HOLD_CYC =
    `FPI_CNT_W'(`FPI_CYC(`FPI_T_HOLD_NS));
  localparam logic [`FPI_CNT_W-1:0] RSTLO_CYC =
    `FPI_CNT_W'(`FPI_CYC(`FPI_T_RSTLO_NS));
  localparam logic [`FPI_CNT_W-1:0] RECOV_CYC =
    `FPI_CNT_W'(`FPI_CYC(`FPI_T_RECOV_NS));

  fpi_state_t              st_q, st_d;
  logic [`FPI_CNT_W-1:0]   cnt_q, cnt_d;
  logic [21:0]             addr_q, addr_d;
  logic [15:0]             wdat_q, wdat_d;
  logic [15:0]             rdat_q, rdat_d;
  logic                    wr_q, wr_d;
  logic                    wide_q, wide_d;
  logic                    pen_q, pen_d;
  logic [2:0]              cs_q, cs_d;
  logic                    rstreq_d;
  logic                    busy_st;
  logic                    acc;
  logic                    go;
  logic [15:0]             lane_mask;

  assign acc = psel & penable;
  assign pready = 1'b1;
  assign busy_st = (st_q != FPI_IDLE);
  assign go = ce & acc & pwrite & (paddr == `FPI_OFF_CTRL)
              & pwdata[`FPI_CTL_GO] & ~busy_st;
  // Upper byte lanes stay released in byte mode
  assign lane_mask = wide_q ? 16'hFFFF : 16'h00FF;

  // Register reads and address decode
  always_comb begin
    prdata  = 32'h0;
    pslverr = 1'b0;
    unique case (paddr)
      `FPI_OFF_CTRL:  prdata = {27'h0, pen_q, wide_q, 1'b0, wr_q, 1'b0};
      `FPI_OFF_ADDR:  prdata = {10'h0, addr_q};
      `FPI_OFF_WDATA: prdata = {16'h0, wdat_q};
      `FPI_OFF_RDATA: prdata = {16'h0, rdat_q};
      `FPI_OFF_STAT:  prdata = {29'h0, (st_q == FPI_RST_LO) |
                                (st_q == FPI_RST_REC),
                                ~controller_status_pin, busy_st};
      `FPI_OFF_CS:    prdata = {29'h0, cs_q};
      default:        pslverr = acc;
    endcase
  end

  // Next state of sequencer and software registers
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    addr_d   = addr_q;
    wdat_d   = wdat_q;
    rdat_d   = rdat_q;
    wr_d     = wr_q;
    wide_d   = wide_q;
    pen_d    = pen_q;
    cs_d     = cs_q;
    rstreq_d = 1'b0;
    if (ce & acc & pwrite & ~busy_st) begin
      unique case (paddr)
        `FPI_OFF_ADDR:  addr_d = pwdata[21:0];
        `FPI_OFF_WDATA: wdat_d = pwdata[15:0];
        `FPI_OFF_CS:    cs_d   = pwdata[2:0];
        `FPI_OFF_CTRL: begin
          wr_d     = pwdata[`FPI_CTL_WR];
          wide_d   = pwdata[`FPI_CTL_WIDE];
          pen_d    = pwdata[`FPI_CTL_PEN];
          rstreq_d = pwdata[`FPI_CTL_RST];
        end
        default: ;
      endcase
    end
    unique case (st_q)
      // Hold reset low the least pulse time
      FPI_RST_LO: begin
        if (cnt_q == RSTLO_CYC) begin
          st_d  = FPI_RST_REC;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      // No bus cycle until recovery has passed
      FPI_RST_REC: begin
        if (cnt_q == RECOV_CYC) begin
          st_d  = FPI_IDLE;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      FPI_IDLE: begin
        if (rstreq_d) begin
          st_d  = FPI_RST_LO;
          cnt_d = '0;
        end else if (go) begin
          st_d  = FPI_SETUP;
          cnt_d = '0;
        end
      end
      // Address stable with device enabled before strobe
      FPI_SETUP: begin
        if (cnt_q == SETUP_CYC - 1'b1) begin
          st_d  = FPI_STROBE;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      FPI_STROBE: begin
        if (cnt_q == STROBE_CYC - 1'b1) begin
          st_d  = FPI_HOLD;
          cnt_d = '0;
          if (!wr_q) begin
            rdat_d = data_bus_lines_in & lane_mask;
          end
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      // Write strobe rises here; address and data held on
      FPI_HOLD: begin
        if (cnt_q == HOLD_CYC - 1'b1) begin
          st_d  = FPI_IDLE;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        st_d  = FPI_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  // State registers; reset starts a memory reset pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q   <= FPI_RST_LO;
      cnt_q  <= '0;
      addr_q <= '0;
      wdat_q <= '0;
      rdat_q <= '0;
      wr_q   <= 1'b0;
      wide_q <= 1'b1;
      pen_q  <= 1'b0;
      cs_q   <= `FPI_CS_RST;
    end else if (ce) begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      wr_q   <= wr_d;
      wide_q <= wide_d;
      pen_q  <= pen_d;
      cs_q   <= cs_d;
    end
  end

  // Pin outputs from registered state
  always_comb begin
    pins.addr = addr_q;
    // Enabled through setup, strobe and hold, so the write strobe
    // alone latches and no select edge races it
    pins.cs = (st_q == FPI_SETUP || st_q == FPI_STROBE ||
               st_q == FPI_HOLD) ? cs_q : 3'h7;
    pins.oe_n = ~((st_q == FPI_SETUP || st_q == FPI_STROBE) & ~wr_q);
    pins.we_n = ~((st_q == FPI_STROBE) & wr_q);
    pins.reset_powerdown_n = (st_q != FPI_RST_LO);
    pins.wide = wide_q;
    pins.program_erase_enable = pen_q;
  end

  // Data bus driven only during writes, only in active lanes
  always_comb begin
    data_bus_lines_out = wdat_q & lane_mask;
    data_bus_lines_oe_n = ((st_q != FPI_IDLE) && (st_q != FPI_RST_LO)
                           && (st_q != FPI_RST_REC) && wr_q)
                          ? ~lane_mask : 16'hFFFF;
  end

  // Bus write strobe and read enable never overlap
  property p_no_contention;
    @(posedge clk) disable iff (rst) !(~pins.oe_n && ~pins.we_n);
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("output and write enable both low");

  // Data driven never while memory outputs enabled
  property p_no_drive_on_read;
    @(posedge clk) disable iff (rst)
      ~pins.oe_n |-> (data_bus_lines_oe_n == 16'hFFFF);
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read)
    else $error("host drives data during read");

  // Upper lanes released in byte mode
  property p_upper_float;
    @(posedge clk) disable iff (rst)
      !wide_q |-> (data_bus_lines_oe_n[15:8] == 8'hFF);
  endproperty
  a_upper_float: assert property (p_upper_float)
    else $error("upper lanes driven in byte mode");

  // Reset pin low for at least eight cycles after it falls
  property p_rst_pulse;
    @(posedge clk) disable iff (rst || !ce)
      $fell(pins.reset_powerdown_n) |-> !pins.reset_powerdown_n [*8];
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("reset pulse too short");

  // No enabled cycle while reset or recovering
  property p_recovery;
    @(posedge clk) disable iff (rst)
      (st_q == FPI_RST_LO || st_q == FPI_RST_REC) |-> pins.cs == 3'h7;
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("memory selected during reset recovery");

  // Address steady and select held where the write strobe rises
  property p_addr_hold;
    @(posedge clk) disable iff (rst || !ce)
      $rose(pins.we_n) |-> $stable(pins.addr) && pins.cs == cs_q;
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address or select moved at strobe end");

  // Data lanes keep driving when write strobe rises
  property p_data_hold;
    @(posedge clk) disable iff (rst || !ce)
      $rose(pins.we_n) |-> data_bus_lines_oe_n == ~lane_mask;
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data released at strobe end");

  // Program enable steady across the strobe of every cycle
  property p_pen_steady;
    @(posedge clk) disable iff (rst)
      (st_q == FPI_STROBE) |=> $stable(pins.program_erase_enable);
  endproperty
  a_pen_steady: assert property (p_pen_steady)
    else $error("program enable changed mid cycle");

endmodule : fpi_host

// ===== fpi_mem_model.sv
// Behavioural parallel flash seen at its pins, sixteen words deep
// Assumes the host changes pins just after clk edges
`timescale 1ns/1ps
`include "fpi_cfg.svh"
module fpi_mem_model
  import fpi_pkg::*;
(
  input  wire logic        clk,
  input  wire fpi_pins_t   pins,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_q,
  output logic      [15:0] dq_en,
  output logic             sts_low
);
  logic [15:0] mem [16];
  logic        sel;
  logic        sel_p;
  logic        we_p;
  logic        hold;
  logic [15:0] w;
  int          busy;
  int          rec;
  localparam int RECOV = `FPI_CYC(`FPI_T_RECOV_NS);
  initial begin
    rec = 0;
    for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
    sel_p = 1'b0;
    we_p = 1'b1;
    hold = 1'b0;
    busy = 0;
  end
  // Select decode, forced off while reset is low or still recovering
  assign sel = pins.reset_powerdown_n & (rec >= RECOV) &
               (pins.cs[2] ? ~&pins.cs[1:0] : ~|pins.cs[1:0]);
  // Latch at the first of strobe rise or deselect edge
  always @(pins.we_n, sel) begin
    if (!we_p && sel_p && (pins.we_n || !sel) && pins.program_erase_enable) begin
      if (pins.wide) mem[pins.addr[4:1]] = dq_in;
      else if (pins.addr[0]) mem[pins.addr[4:1]][15:8] = dq_in[7:0];
      else mem[pins.addr[4:1]][7:0] = dq_in[7:0];
      busy = 40;
    end
    we_p = pins.we_n;
    sel_p = sel;
  end
  // Busy count; a reset aborts it and keeps the pin low until release
  always @(posedge clk) begin
    if (!pins.reset_powerdown_n) begin
      hold = hold | (busy != 0);
      busy = 0;
      rec = 0;
    end else begin
      hold = 1'b0;
      if (busy != 0) busy = busy - 1;
      if (rec < RECOV) rec = rec + 1;
    end
  end
  // Open drain: only ever pulls low, ready/busy mode only
  assign sts_low = (busy != 0) | hold;
  // Read drive: array data, status with bit seven low while busy
  always_comb begin
    w = mem[pins.addr[4:1]];
    dq_en = (sel & ~pins.oe_n) ? (pins.wide ? 16'hFFFF : 16'h00FF) : 16'h0000;
    dq_q = (busy != 0) ? 16'h0000 : pins.wide ? w
         : {8'h00, pins.addr[0] ? w[15:8] : w[7:0]};
  end
endmodule : fpi_mem_model

// ===== tb_top.sv
// Self-checking bench: APB master, flash model on the pin side
// Assumes the design's timing macros and a pull-up on the status pin
`timescale 1ns/1ps
`include "fpi_cfg.svh"
module tb_top
  import fpi_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  fpi_pins_t   pins;
  logic [15:0] dq_out;
  logic [15:0] dq_oe_n;
  logic [15:0] dq_q;
  logic [15:0] dq_en;
  logic [15:0] dq;
  logic [15:0] last = 16'h0000;
  logic        sts_low;
  logic [31:0] r;
  logic        e;
  logic [15:0] shadow [16];
  int          miscompares = 0;
  int          total_checks = 0;
  always #2.5 clk = ~clk;
  // Wire level: host drive, else model, else a changing float pattern
  assign dq = (~dq_oe_n & dq_out) | (dq_oe_n & ((dq_en & dq_q) | (~dq_en & ~last)));
  always @(posedge clk) last <= dq;
  fpi_host i_fpi_host (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .data_bus_lines_in(dq), .data_bus_lines_out(dq_out),
    .data_bus_lines_oe_n(dq_oe_n), .controller_status_pin(~sts_low));
  fpi_mem_model i_fpi_mem_model (.clk(clk), .pins(pins), .dq_in(dq),
    .dq_q(dq_q), .dq_en(dq_en), .sts_low(sts_low));
  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      miscompares++;
      $display("Error %0t: got %h want %h", $time, s, x);
    end
  endtask : chk
  // One APB transfer, setup then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      $display("Error %0t: bus answer timed out", $time);
      results();
    end
  endtask : apb
  // Poll one status bit until it clears
  task automatic wt(input int b, input int lim);
    int n;
    n = 0;
    do begin apb(1'b0, `FPI_OFF_STAT, 32'h0); n++; end
    while (r[b] !== 1'b0 && n < lim);
    if (n >= lim) begin
      miscompares++;
      $display("Error %0t: status poll timed out", $time);
      results();
    end
  endtask : wt
  task automatic op(input logic [4:0] c, input logic [21:0] a,
                    input logic [15:0] d, input logic [2:0] s);
    apb(1'b1, `FPI_OFF_ADDR, {10'h000, a});
    apb(1'b1, `FPI_OFF_WDATA, {16'h0000, d});
    apb(1'b1, `FPI_OFF_CS, {29'h0, s});
    apb(1'b1, `FPI_OFF_CTRL, {27'h0, c});
    wt(`FPI_ST_BUSY, 3000);
  endtask : op
  task automatic rd(input logic [21:0] a, input logic [2:0] s, input logic [4:0] c);
    op(c, a, 16'h0000, s);
    apb(1'b0, `FPI_OFF_RDATA, 32'h0);
  endtask : rd
  function automatic logic dec(input logic [2:0] s);
    return s[2] ? !(s[1] && s[0]) : !(s[1] || s[0]);
  endfunction : dec
  // Main sequence
  initial begin
    logic [21:0] a;
    logic [15:0] d;
    for (int i = 0; i < 16; i++) shadow[i] = 16'h0000;
    void'($urandom(32'h7449));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `FPI_OFF_STAT, 32'h0);
    chk(r & 32'h7, 32'h5);
    wt(`FPI_ST_BUSY, 3000);
    chk(r & 32'h7, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk({r[30:0], e}, 32'h1);
    // Random word traffic with enabled select patterns
    for (int i = 0; i < 8; i++) begin
      a = 22'($urandom_range(15)) << 1;
      d = 16'($urandom);
      op(5'h1B, a, d, 3'h4);
      shadow[a[4:1]] = d;
      apb(1'b0, `FPI_OFF_STAT, 32'h0);
      chk(32'(r[1]), 32'h1);
      wt(`FPI_ST_STSLO, 100);
      rd(a, 3'($urandom_range(6, 4)), 5'h09);
      chk(32'(r[15:0]), 32'(shadow[a[4:1]]));
    end
    // Byte lanes of words zero and one
    for (int i = 0; i < 4; i++) begin
      a = 22'(i);
      d = 16'($urandom);
      op(5'h13, a, d, 3'h0);
      shadow[a[4:1]][a[0]*8 +: 8] = d[7:0];
      wt(`FPI_ST_STSLO, 100);
      rd(a, 3'h0, 5'h01);
      chk(32'(r[7:0]), 32'(d[7:0]));
    end
    rd(22'h0, 3'h4, 5'h09);
    chk(32'(r[15:0]), 32'(shadow[0]));
    // Every select pattern, checked through a later read
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      op(5'h1B, 22'h4, d, 3'(i));
      if (dec(3'(i))) shadow[2] = d;
      wt(`FPI_ST_STSLO, 100);
      rd(22'h4, 3'h4, 5'h09);
      chk(32'(r[15:0]), 32'(shadow[2]));
    end
    // Program with the enable low leaves the array alone
    op(5'h0B, 22'h6, 16'h55AA, 3'h4);
    apb(1'b0, `FPI_OFF_STAT, 32'h0);
    chk(32'(r[1]), 32'h0);
    rd(22'h6, 3'h4, 5'h09);
    chk(32'(r[15:0]), 32'(shadow[3]));
    // Reset during a busy operation
    op(5'h1B, 22'h8, 16'hA5A5, 3'h4);
    apb(1'b1, `FPI_OFF_CTRL, 32'h4);
    apb(1'b0, `FPI_OFF_STAT, 32'h0);
    chk(r & 32'h7, 32'h7);
    wt(`FPI_ST_BUSY, 3000);
    chk(r & 32'h7, 32'h0);
    // Clock enable low freezes the register file
    ce <= 1'b0;
    apb(1'b1, `FPI_OFF_ADDR, 32'h0012_3456);
    ce <= 1'b1;
    apb(1'b0, `FPI_OFF_ADDR, 32'h0);
    chk(r, 32'h0000_0008);
    apb(1'b1, `FPI_OFF_ADDR, 32'h0012_3456);
    apb(1'b0, `FPI_OFF_ADDR, 32'h0);
    chk(r, 32'h0012_3456);
    results();
  end
endmodule : tb_top
